// file: design/logic_pattern_trigger.sv
// Boolean pattern trigger with two stored programs and an AXI4-Lite register port
//
// Added by the designer: the AXI4-Lite interface to the registers and the address map.
`timescale 1ns/1ps

// Overview of operation
// (RQ1) Two separate programs A and B stored
// (RQ2) Select picks program for entry and use
// (RQ3) Trigger while inputs satisfy active function
// (RQ4) Product term ANDs inputs, each optionally inverted
// (RQ5) Trigger to timebase; out unless sync mode
// (RQ6) Trace follows trigger exactly in time
// (RQ7) Qualify evaluation on chosen clock edge
// (RQ8) Per-input threshold defaults to family preset
// (RQ9) Raise/lower only in channel mode, monitor on
// (RQ10) Filter suppresses true intervals below duration; code bypasses the filter whenever program A has an edge input
// (RQ11) Inversion key toggles until delimiter entered
// (RQ12) One edge input per term, newest wins
// (RQ13) Clear erases only the displayed program
// (RQ14) Sequential: A arms, B triggers, reset
// (RQ15) Inputs synchronised; edges from consecutive samples
// (RQ16) Filter counts cycles, restarts when false
module logic_pattern_trigger
   import trig_pkg::*;
#(
   parameter int FILT_W = 16
) (
   input  wire logic        SYS_CLK,
   input  wire logic        RST_N,
   input  wire logic        CLK_EN,
   input  wire logic [3:0]  PROBE_IN,
   input  wire logic        QUAL_CLK_IN,
   output logic             TIMEBASE_TRIG,
   output logic             TRIG_OUT,
   output logic             TRIG_TRACE_OUT,
   output logic [31:0]      THRESHOLDS,
   output logic             IRQ,
   input  wire logic [7:0]  S_AXI_AWADDR,
   input  wire logic        S_AXI_AWVALID,
   output logic             S_AXI_AWREADY,
   input  wire logic [31:0] S_AXI_WDATA,
   input  wire logic [3:0]  S_AXI_WSTRB,
   input  wire logic        S_AXI_WVALID,
   output logic             S_AXI_WREADY,
   output logic [1:0]       S_AXI_BRESP,
   output logic             S_AXI_BVALID,
   input  wire logic        S_AXI_BREADY,
   input  wire logic [7:0]  S_AXI_ARADDR,
   input  wire logic        S_AXI_ARVALID,
   output logic             S_AXI_ARREADY,
   output logic [31:0]      S_AXI_RDATA,
   output logic [1:0]       S_AXI_RRESP,
   output logic             S_AXI_RVALID,
   input  wire logic        S_AXI_RREADY
);

   initial begin
      if (FILT_W < 1 || FILT_W > 32) $error("FILT_W out of range");
   end

   // Register state
   logic [6:0]        ctrl_q;
   logic [FILT_W-1:0] filt_q;
   logic [1:0]        thr_sel_q;
   logic [1:0]        irq_stat_q;
   logic [1:0]        irq_mask_q;
   logic [7:0]        thr_q [4];
   logic [3:0]        thr_custom_q;
   program_t          prog_q [2];
   logic              sel_q;
   logic              seq_rst_q;

   // Input synchronisers and samples
   logic [3:0] in_m_q, in_s_q, in_p_q;
   logic [2:0] qclk_q;

   // Bus handshake state
   logic        aw_hold_q, w_hold_q;
   logic [7:0]  aw_addr_q;
   logic [31:0] w_data_q;
   logic [3:0]  w_strb_q;

   // Trigger path state
   logic [FILT_W-1:0] fcnt_q;
   logic              trig_q;
   seq_state_t        seq_q;

   logic       wr_fire;
   logic [7:0] wr_addr;
   logic [31:0] wr_data;
   logic       key_fire;
   logic [3:0] key_code;
   logic [1:0] key_ch;

   // Write happens once both address and data are held
   assign wr_fire  = aw_hold_q && w_hold_q && !S_AXI_BVALID;
   assign wr_addr  = aw_addr_q;
   assign wr_data  = w_data_q;
   assign key_fire = wr_fire && (wr_addr == KEY_OFS) && w_strb_q[0];
   assign key_code = wr_data[3:0];
   assign key_ch   = wr_data[5:4];

   // Two-stage synchronisers; third stage keeps the previous sample for edges
   always_ff @(posedge SYS_CLK) begin
      if (!RST_N) begin
         in_m_q <= 4'h0;
         in_s_q <= 4'h0;
         in_p_q <= 4'h0;
         qclk_q <= 3'h0;
      end else if (CLK_EN) begin
         in_m_q <= PROBE_IN;                             // [RQ15]
         in_s_q <= in_m_q;
         in_p_q <= in_s_q;                               // [RQ15]
         qclk_q <= {qclk_q[1:0], QUAL_CLK_IN};
      end
   end

   // AXI write channel: address and data taken in either order
   assign S_AXI_AWREADY = !aw_hold_q;
   assign S_AXI_WREADY  = !w_hold_q;
   assign S_AXI_BRESP   = 2'h0;
   always_ff @(posedge SYS_CLK) begin
      if (!RST_N) begin
         aw_hold_q    <= 1'b0;
         w_hold_q     <= 1'b0;
         aw_addr_q    <= 8'h00;
         w_data_q     <= 32'h0000_0000;
         w_strb_q     <= 4'h0;
         S_AXI_BVALID <= 1'b0;
      end else if (CLK_EN) begin
         if (S_AXI_AWVALID && !aw_hold_q) begin
            aw_hold_q <= 1'b1;
            aw_addr_q <= {S_AXI_AWADDR[7:2], 2'b00};
         end
         if (S_AXI_WVALID && !w_hold_q) begin
            w_hold_q <= 1'b1;
            w_data_q <= S_AXI_WDATA;
            w_strb_q <= S_AXI_WSTRB;
         end
         if (wr_fire) begin
            S_AXI_BVALID <= 1'b1;
         end else if (S_AXI_BVALID && S_AXI_BREADY) begin
            S_AXI_BVALID <= 1'b0;
            aw_hold_q    <= 1'b0;
            w_hold_q     <= 1'b0;
         end
      end
   end

   // Plain configuration registers; unmapped writes are accepted and dropped
   always_ff @(posedge SYS_CLK) begin
      if (!RST_N) begin
         ctrl_q     <= 7'h00;
         filt_q     <= FILT_RESET[FILT_W-1:0];
         thr_sel_q  <= 2'h0;
         irq_mask_q <= 2'h0;
      end else if (CLK_EN && wr_fire && w_strb_q[0]) begin
         case (wr_addr)
            CTRL_OFS:     ctrl_q     <= wr_data[6:0];
            FILT_OFS:     filt_q     <= wr_data[FILT_W-1:0];
            THR_SEL_OFS:  thr_sel_q  <= wr_data[1:0];
            IRQ_MASK_OFS: irq_mask_q <= wr_data[1:0];
            default: ;
         endcase
      end
   end

   // Thresholds: every family change reloads the preset on all inputs, those set on their own included
   logic ecl_prev_q;
   always_ff @(posedge SYS_CLK) begin
      if (!RST_N) begin
         for (int i = 0; i < 4; i++) thr_q[i] <= THR_TTL_PRESET;
         thr_custom_q <= 4'h0;
         ecl_prev_q   <= 1'b0;
      end else if (CLK_EN) begin
         ecl_prev_q <= ctrl_q[CTRL_ECL];
         if (ctrl_q[CTRL_ECL] != ecl_prev_q) begin
            // Family change cancels every individual setting
            for (int i = 0; i < 4; i++)
               thr_q[i] <= ctrl_q[CTRL_ECL] ? THR_ECL_PRESET : THR_TTL_PRESET; // [RQ8]
            thr_custom_q <= 4'h0;
         end else if (key_fire && ctrl_q[CTRL_PROGRAM_CHANNEL_MODE] && ctrl_q[CTRL_THR_MON]) begin // [RQ9]
            // Saturate so a held key cannot wrap the level around
            if (key_code == KEY_RAISE && thr_q[thr_sel_q] != 8'hFF) begin
               thr_q[thr_sel_q]        <= thr_q[thr_sel_q] + 8'h01;
               thr_custom_q[thr_sel_q] <= 1'b1;
            end else if (key_code == KEY_LOWER && thr_q[thr_sel_q] != 8'h00) begin
               thr_q[thr_sel_q]        <= thr_q[thr_sel_q] - 8'h01;
               thr_custom_q[thr_sel_q] <= 1'b1;
            end
         end
      end
   end

   assign THRESHOLDS = {thr_q[3], thr_q[2], thr_q[1], thr_q[0]};

   // Program entry from the key register
   always_ff @(posedge SYS_CLK) begin
      if (!RST_N) begin
         prog_q[0] <= '0;
         prog_q[1] <= '0;                                // [RQ1]
         sel_q     <= 1'b0;
         seq_rst_q <= 1'b0;
      end else if (CLK_EN) begin
         seq_rst_q <= key_fire && key_code == KEY_SEQ_RESET;
         if (key_fire && !ctrl_q[CTRL_PROGRAM_CHANNEL_MODE]) begin
            case (key_code)
               KEY_SEL_A: sel_q <= 1'b0;                 // [RQ2]
               KEY_SEL_B: sel_q <= 1'b1;                 // [RQ2]
               KEY_CLEAR: prog_q[sel_q] <= '0;           // [RQ13]
               KEY_INPUT: prog_q[sel_q].terms[prog_q[sel_q].cur].used[key_ch] <= 1'b1;
               KEY_NOT: begin
                  // Toggles the input named in the key write (key_ch) within the open term
                  prog_q[sel_q].terms[prog_q[sel_q].cur].inv[key_ch] <=
                     !prog_q[sel_q].terms[prog_q[sel_q].cur].inv[key_ch]; // [RQ11]
                  prog_q[sel_q].terms[prog_q[sel_q].cur].used[key_ch] <= 1'b1;
               end
               KEY_EDGE: begin
                  prog_q[sel_q].terms[prog_q[sel_q].cur].used[key_ch] <= 1'b1;
                  if (prog_q[sel_q].terms[prog_q[sel_q].cur].edge_sel[key_ch]) begin
                     // Reverting newest edge hands status back to the older one
                     prog_q[sel_q].terms[prog_q[sel_q].cur].edge_sel <=
                        prog_q[sel_q].terms[prog_q[sel_q].cur].edge_prev; // [RQ12]
                     prog_q[sel_q].terms[prog_q[sel_q].cur].edge_prev <= 4'h0;
                  end else begin
                     prog_q[sel_q].terms[prog_q[sel_q].cur].edge_prev <=
                        prog_q[sel_q].terms[prog_q[sel_q].cur].edge_sel;
                     prog_q[sel_q].terms[prog_q[sel_q].cur].edge_sel <= 4'h1 << key_ch; // [RQ12]
                  end
               end
               KEY_AND: ;                                // Terms are AND by nature
               KEY_OR: prog_q[sel_q].cur <= 1'b1;        // Delimiter closes the first term [RQ11]
               default: ;
            endcase
         end
      end
   end

   // Boolean evaluation of one program: OR of product terms
   function automatic logic eval_prog(input program_t p, input logic [3:0] cur_s, input logic [3:0] prv_s);
      logic r;
      logic t;
      logic lvl;
      r = 1'b0;
      for (int k = 0; k < NUM_TERMS; k++) begin
         t = |p.terms[k].used;
         for (int c = 0; c < 4; c++) begin
            lvl = cur_s[c] ^ p.terms[k].inv[c];          // [RQ4]
            if (p.terms[k].used[c]) begin
               if (p.terms[k].edge_sel[c])
                  t = t & lvl & (prv_s[c] == p.terms[k].inv[c]); // [RQ15]
               else
                  t = t & lvl;
            end
         end
         r = r | t;
      end
      return r;
   endfunction

   logic fa, fb, func_true, qual_ok, filt_pass, has_edge_a;
   assign fa = eval_prog(prog_q[0], in_s_q, in_p_q);
   assign fb = eval_prog(prog_q[1], in_s_q, in_p_q);
   assign has_edge_a = |{prog_q[0].terms[0].edge_sel, prog_q[0].terms[1].edge_sel};
   // Qualifying edge from the synchronised external clock
   assign qual_ok = !ctrl_q[CTRL_QUAL_EN] ||
                    (ctrl_q[CTRL_QUAL_FALL] ? (qclk_q[2] && !qclk_q[1]) : (!qclk_q[2] && qclk_q[1])); // [RQ7]
   // Active function: selected program, or A in sequential mode
   assign func_true = (ctrl_q[CTRL_SEQ] ? fa : (sel_q ? fb : fa)) && qual_ok; // [RQ3]
   assign filt_pass = (fcnt_q >= filt_q) || has_edge_a;

   // Duration filter: counts true cycles, restarts on false
   always_ff @(posedge SYS_CLK) begin
      if (!RST_N) begin
         fcnt_q <= '0;
      end else if (CLK_EN) begin
         if (!func_true)
            fcnt_q <= '0;                                // [RQ16]
         else if (fcnt_q < filt_q)
            fcnt_q <= fcnt_q + 1'b1;                     // [RQ10]
      end
   end

   // Trigger generation with optional A-then-B sequencing
   always_ff @(posedge SYS_CLK) begin
      if (!RST_N) begin
         trig_q <= 1'b0;
         seq_q  <= SEQ_WAIT_A;
      end else if (CLK_EN) begin
         if (!ctrl_q[CTRL_SEQ]) begin
            trig_q <= func_true && filt_pass;            // [RQ10]
            seq_q  <= SEQ_WAIT_A;
         end else if (seq_rst_q) begin
            trig_q <= 1'b0;
            seq_q  <= SEQ_WAIT_A;                        // [RQ14]
         end else begin
            case (seq_q)
               SEQ_WAIT_A: begin
                  trig_q <= 1'b0;
                  if (func_true && filt_pass) seq_q <= SEQ_ARMED; // [RQ14]
               end
               SEQ_ARMED: begin
                  trig_q <= fb && qual_ok;
                  if (fb && qual_ok) seq_q <= SEQ_FIRE;  // [RQ14]
               end
               SEQ_FIRE: begin
                  trig_q <= fb && qual_ok;
                  if (!(fb && qual_ok)) seq_q <= SEQ_WAIT_A;
               end
               default: seq_q <= SEQ_WAIT_A;
            endcase
         end
      end
   end

   assign TIMEBASE_TRIG  = trig_q;                                  // [RQ5]
   assign TRIG_OUT       = trig_q && !ctrl_q[CTRL_EXT_SYNC];        // [RQ5]
   assign TRIG_TRACE_OUT = trig_q;                                  // [RQ6]

   // Sticky interrupt flags; a new event wins over a clearing write
   logic trig_prev_q, armed_prev_q;
   always_ff @(posedge SYS_CLK) begin
      if (!RST_N) begin
         irq_stat_q   <= 2'h0;
         trig_prev_q  <= 1'b0;
         armed_prev_q <= 1'b0;
      end else if (CLK_EN) begin
         trig_prev_q  <= trig_q;
         armed_prev_q <= (seq_q == SEQ_ARMED);
         irq_stat_q   <= (irq_stat_q &
                         ~((wr_fire && wr_addr == IRQ_STAT_OFS && w_strb_q[0]) ? wr_data[1:0] : 2'h0)) |
                         {(seq_q == SEQ_ARMED) && !armed_prev_q, trig_q && !trig_prev_q};
      end
   end
   assign IRQ = |(irq_stat_q & irq_mask_q);

   // AXI read channel: one-cycle registered answer
   assign S_AXI_ARREADY = !S_AXI_RVALID;
   assign S_AXI_RRESP   = 2'h0;
   always_ff @(posedge SYS_CLK) begin
      if (!RST_N) begin
         S_AXI_RVALID <= 1'b0;
         S_AXI_RDATA  <= 32'h0000_0000;
      end else if (CLK_EN) begin
         if (S_AXI_ARVALID && !S_AXI_RVALID) begin
            S_AXI_RVALID <= 1'b1;
            case ({S_AXI_ARADDR[7:2], 2'b00})
               CTRL_OFS:     S_AXI_RDATA <= {25'h0, ctrl_q};
               FILT_OFS:     S_AXI_RDATA <= 32'(filt_q);
               THR_SEL_OFS:  S_AXI_RDATA <= {30'h0, thr_sel_q};
               STATUS_OFS:   S_AXI_RDATA <= {17'h0, seq_q, thr_custom_q, in_s_q, sel_q, fb, fa, trig_q};
               IRQ_STAT_OFS: S_AXI_RDATA <= {30'h0, irq_stat_q};
               IRQ_MASK_OFS: S_AXI_RDATA <= {30'h0, irq_mask_q};
               THR0_OFS:     S_AXI_RDATA <= THRESHOLDS;
               default:      S_AXI_RDATA <= 32'h0000_0000;
            endcase
         end else if (S_AXI_RVALID && S_AXI_RREADY) begin
            S_AXI_RVALID <= 1'b0;
         end
      end
   end

endmodule

// file: design/trig_pkg.sv
// Package: constants, register map and carrier types of the pattern trigger
package trig_pkg;

   // Register byte offsets
   localparam logic [7:0] CTRL_OFS     = 8'h00;
   localparam logic [7:0] KEY_OFS      = 8'h04;
   localparam logic [7:0] FILT_OFS     = 8'h08;
   localparam logic [7:0] THR_SEL_OFS  = 8'h0C;
   localparam logic [7:0] STATUS_OFS   = 8'h10;
   localparam logic [7:0] IRQ_STAT_OFS = 8'h14;
   localparam logic [7:0] IRQ_MASK_OFS = 8'h18;
   localparam logic [7:0] THR0_OFS     = 8'h20;

   // Control register bit positions
   localparam int CTRL_QUAL_EN   = 0;
   localparam int CTRL_QUAL_FALL = 1;
   localparam int CTRL_SEQ       = 2;
   localparam int CTRL_ECL       = 3;
   localparam int CTRL_PROGRAM_CHANNEL_MODE = 4;
   localparam int CTRL_THR_MON   = 5;
   localparam int CTRL_EXT_SYNC  = 6;

   // Key codes written to the key register
   localparam logic [3:0] KEY_INPUT = 4'h0;
   localparam logic [3:0] KEY_NOT   = 4'h1;
   localparam logic [3:0] KEY_EDGE  = 4'h2;
   localparam logic [3:0] KEY_AND   = 4'h3;
   localparam logic [3:0] KEY_OR    = 4'h4;
   localparam logic [3:0] KEY_CLEAR = 4'h5;
   localparam logic [3:0] KEY_SEL_A = 4'h6;
   localparam logic [3:0] KEY_SEL_B = 4'h7;
   localparam logic [3:0] KEY_RAISE = 4'h8;
   localparam logic [3:0] KEY_LOWER = 4'h9;
   localparam logic [3:0] KEY_SEQ_RESET = 4'hA;

   // Reset values, family presets and the term count
   localparam logic [7:0] THR_TTL_PRESET = 8'h8E;
   localparam logic [7:0] THR_ECL_PRESET = 8'h3B;
   localparam logic [15:0] FILT_RESET    = 16'h0000;
   localparam int NUM_TERMS = 2;

   // Interrupt status bits
   localparam int IRQ_TRIG = 0;
   localparam int IRQ_ARM  = 1;

   // One product term: used inputs, inversion, edge flags, edge history
   typedef struct packed {
      logic [3:0] used;
      logic [3:0] inv;
      logic [3:0] edge_sel;
      logic [3:0] edge_prev;
   } term_t;

   // One stored trigger-function program
   typedef struct packed {
      term_t [NUM_TERMS-1:0] terms;
      logic  [0:0]           cur;
   } program_t;

   typedef enum logic [2:0] {
      SEQ_WAIT_A = 3'b001,
      SEQ_ARMED  = 3'b010,
      SEQ_FIRE   = 3'b100
   } seq_state_t;

endpackage

// file: bench/lpt_chk.sv
// Port-level assertions for the pattern trigger, bound into the design
`timescale 1ns/1ps
module lpt_chk
   import trig_pkg::*;
(
   input wire logic        SYS_CLK,
   input wire logic        RST_N,
   input wire logic        TIMEBASE_TRIG,
   input wire logic        TRIG_OUT,
   input wire logic        TRIG_TRACE_OUT,
   input wire logic [31:0] THRESHOLDS,
   input wire logic        IRQ,
   input wire logic        S_AXI_AWVALID,
   input wire logic        S_AXI_AWREADY,
   input wire logic        S_AXI_WVALID,
   input wire logic        S_AXI_WREADY,
   input wire logic        S_AXI_BVALID,
   input wire logic        S_AXI_BREADY,
   input wire logic [1:0]  S_AXI_BRESP,
   input wire logic        S_AXI_ARVALID,
   input wire logic        S_AXI_ARREADY,
   input wire logic        S_AXI_RVALID,
   input wire logic [1:0]  S_AXI_RRESP
);
   default clocking cb @(posedge SYS_CLK); endclocking
   default disable iff (!RST_N);

   // Output paths
   a_trace_follows: assert property (TRIG_TRACE_OUT == TIMEBASE_TRIG) else $error("trace differs from trigger");
   a_out_gated: assert property (TRIG_OUT |-> TIMEBASE_TRIG) else $error("trigger out without trigger");
   a_thr_preset: assert property (!$past(RST_N) |-> THRESHOLDS == {4{THR_TTL_PRESET}})
      else $error("thresholds not at preset after reset");
   // Thresholds move only after a write
   a_thr_by_write: assert property ($past(RST_N) && !$stable(THRESHOLDS) |-> S_AXI_BVALID || $past(S_AXI_BVALID))
      else $error("thresholds changed without a write");

   // Register port
   a_write_answer: assert property (S_AXI_AWVALID && S_AXI_AWREADY && S_AXI_WVALID && S_AXI_WREADY
      |-> ##[1:2] S_AXI_BVALID) else $error("write response late");
   a_read_answer: assert property (S_AXI_ARVALID && S_AXI_ARREADY |=> S_AXI_RVALID) else $error("read data late");
   a_write_blocked: assert property (S_AXI_BVALID |-> !S_AXI_AWREADY && !S_AXI_WREADY)
      else $error("ready while response pending");
   a_resp_okay: assert property (S_AXI_BVALID || S_AXI_RVALID |-> S_AXI_BRESP == 2'b00 && S_AXI_RRESP == 2'b00)
      else $error("response not okay");
   a_b_single: assert property (S_AXI_BVALID && S_AXI_BREADY |=> !S_AXI_BVALID) else $error("response repeated");

   // Main scenarios reached
   c_trig_rise: cover property ($rose(TIMEBASE_TRIG));
   c_out_gated: cover property (TIMEBASE_TRIG && !TRIG_OUT);
   c_irq: cover property (IRQ);
endmodule

bind logic_pattern_trigger lpt_chk i_chk (
   .SYS_CLK(SYS_CLK), .RST_N(RST_N), .TIMEBASE_TRIG(TIMEBASE_TRIG), .TRIG_OUT(TRIG_OUT),
   .TRIG_TRACE_OUT(TRIG_TRACE_OUT), .THRESHOLDS(THRESHOLDS), .IRQ(IRQ),
   .S_AXI_AWVALID(S_AXI_AWVALID), .S_AXI_AWREADY(S_AXI_AWREADY), .S_AXI_WVALID(S_AXI_WVALID),
   .S_AXI_WREADY(S_AXI_WREADY), .S_AXI_BVALID(S_AXI_BVALID), .S_AXI_BREADY(S_AXI_BREADY),
   .S_AXI_BRESP(S_AXI_BRESP), .S_AXI_ARVALID(S_AXI_ARVALID), .S_AXI_ARREADY(S_AXI_ARREADY),
   .S_AXI_RVALID(S_AXI_RVALID), .S_AXI_RRESP(S_AXI_RRESP)
);

// file: bench/probe_model.sv
// Circuit-under-test model: four logic levels and a qualifying clock
`timescale 1ns/1ps
module probe_model (
   input  wire logic  clk,
   output logic [3:0] probe,
   output logic       qclk
);
   // Levels idle low; no phase is promised
   initial begin
      probe = 4'h0;
      qclk  = 1'b0;
   end

   // New levels land just after a bench edge
   task automatic set_in(input logic [3:0] p);
      @(posedge clk);
      probe <= p;
   endtask

   task automatic set_q(input logic v);
      @(posedge clk);
      qclk <= v;
   endtask
endmodule

// file: bench/logic_pattern_trigger_tb.sv
// Self-checking bench for the pattern trigger with a behavioural program model
`timescale 1ns/1ps
module logic_pattern_trigger_tb
   import trig_pkg::*;
();
   logic        sys_clk = 1'b0;
   logic        rst_n   = 1'b0;
   logic [3:0]  probe;
   logic        qclk;
   logic        tb_trig, tr_out, tr_view, irq;
   logic [31:0] thr, rdata;
   logic [31:0] wdata   = 32'h0;
   logic [7:0]  awaddr  = 8'h00, araddr = 8'h00;
   logic        awvalid = 1'b0, wvalid = 1'b0, bready = 1'b0, arvalid = 1'b0, rready = 1'b0;
   logic        awready, wready, bvalid, arready, rvalid;
   logic [1:0]  bresp, rresp;
   logic [3:0]  used [2][2] = '{default: 4'h0};
   logic [3:0]  inv [2][2]  = '{default: 4'h0};
   logic        xs = 1'b0, clk_en = 1'b1;
   logic [3:0]  wstrb = 4'hF;
   int          sel = 0, hi = 0, cyc = 0, h0 = 0, fails = 0, num_checks = 0, seed = 49981;
   int          term [2] = '{0, 0};

   logic_pattern_trigger #(.FILT_W(16)) i_dut (
      .SYS_CLK(sys_clk), .RST_N(rst_n), .CLK_EN(clk_en), .PROBE_IN(probe), .QUAL_CLK_IN(qclk),
      .TIMEBASE_TRIG(tb_trig), .TRIG_OUT(tr_out), .TRIG_TRACE_OUT(tr_view), .THRESHOLDS(thr), .IRQ(irq),
      .S_AXI_AWADDR(awaddr), .S_AXI_AWVALID(awvalid), .S_AXI_AWREADY(awready), .S_AXI_WDATA(wdata),
      .S_AXI_WSTRB(wstrb), .S_AXI_WVALID(wvalid), .S_AXI_WREADY(wready), .S_AXI_BRESP(bresp),
      .S_AXI_BVALID(bvalid), .S_AXI_BREADY(bready), .S_AXI_ARADDR(araddr), .S_AXI_ARVALID(arvalid),
      .S_AXI_ARREADY(arready), .S_AXI_RDATA(rdata), .S_AXI_RRESP(rresp), .S_AXI_RVALID(rvalid),
      .S_AXI_RREADY(rready)
   );
   probe_model i_probe (.clk(sys_clk), .probe(probe), .qclk(qclk));

   // 100 MHz clock
   initial begin
      forever #5 sys_clk = ~sys_clk;
   end

   // Watchdog and count of trigger-high cycles
   always @(posedge sys_clk) begin
      cyc <= cyc + 1;
      if (tb_trig === 1'b1) hi <= hi + 1;
      if (cyc == 20000) begin
         fails++;
         end_sim();
      end
   end

   task automatic chk_bit(input string n, input logic e, input logic g);
      num_checks++;
      if (g !== e) begin
         fails++;
         $display("ERROR %s expected %b seen %b", n, e, g);
      end
   endtask

   task automatic chk_word(input string n, input logic [31:0] e, input logic [31:0] g);
      num_checks++;
      if (g !== e) begin
         fails++;
         $display("ERROR %s expected %h seen %h", n, e, g);
      end
   endtask

   // Write: address and data offered together, each released once taken
   task automatic wr(input logic [7:0] a, input logic [31:0] d);
      logic aw_p, w_p;
      aw_p = 1'b1;
      w_p  = 1'b1;
      @(posedge sys_clk);
      awaddr  <= a;
      wdata   <= d;
      awvalid <= 1'b1;
      wvalid  <= 1'b1;
      bready  <= 1'b1;
      while (aw_p || w_p) begin
         @(posedge sys_clk);
         if (aw_p && awready === 1'b1) begin
            aw_p = 1'b0;
            awvalid <= 1'b0;
         end
         if (w_p && wready === 1'b1) begin
            w_p = 1'b0;
            wvalid <= 1'b0;
         end
      end
      while (bvalid !== 1'b1) @(posedge sys_clk);
      bready <= 1'b0;
   endtask

   task automatic rchk(input logic [7:0] a, input logic [31:0] e);
      @(posedge sys_clk);
      araddr  <= a;
      arvalid <= 1'b1;
      rready  <= 1'b1;
      do @(posedge sys_clk); while (arready !== 1'b1);
      arvalid <= 1'b0;
      do @(posedge sys_clk); while (rvalid !== 1'b1);
      rready <= 1'b0;
      chk_word("read data", e, rdata);
   endtask

   // Key entry, mirrored in the model
   task automatic key(input logic [3:0] c, input int i);
      wr(KEY_OFS, {26'h0, 2'(i), c});
      case (c)
         KEY_INPUT: used[sel][term[sel]][i] = 1'b1;
         KEY_NOT:   inv[sel][term[sel]][i] = ~inv[sel][term[sel]][i];
         KEY_OR:    term[sel] = 1;
         KEY_SEL_A: sel = 0;
         KEY_SEL_B: sel = 1;
         KEY_CLEAR: begin
            used[sel] = '{4'h0, 4'h0};
            inv[sel]  = '{4'h0, 4'h0};
            term[sel] = 0;
         end
         default: ;
      endcase
   endtask

   // Active program's terms; an empty term never matches
   function automatic logic f_eval(input logic [3:0] x);
      logic r;
      r = 1'b0;
      for (int t = 0; t < 2; t++) begin
         if (used[sel][t] != 4'h0 && ((x ^ inv[sel][t]) & used[sel][t]) == used[sel][t])
            r = 1'b1;
      end
      return r;
   endfunction

   // Drive a pattern, then compare all trigger paths
   task automatic apply(input logic [3:0] p);
      i_probe.set_in(p);
      repeat (4) @(posedge sys_clk);
      #1;
      chk_bit("trigger", f_eval(p), tb_trig);
      chk_bit("trace", f_eval(p), tr_view);
      chk_bit("trigger out", f_eval(p) & ~xs, tr_out);
   endtask

   task automatic irqchk(input logic e);
      @(posedge sys_clk);
      #1;
      chk_bit("irq", e, irq);
   endtask

   task automatic end_sim();
      $display("checks %0d mismatches %0d", num_checks, fails);
      if (fails == 0 && num_checks > 0)
         $display("NO MISMATCHES");
      else
         $display("MISMATCHES SEEN");
      $finish;
   endtask

   initial begin
      repeat (5) @(posedge sys_clk);
      rst_n <= 1'b1;
      rchk(THR0_OFS, {4{THR_TTL_PRESET}});
      rchk(8'hFC, 32'h0);
      $display("test reset done");
      // Program A: not one, two, not three, four; matches only pattern 1010
      key(KEY_SEL_A, 0);
      for (int i = 0; i < 4; i++) begin
         key(KEY_INPUT, i);
         if (i % 2 == 0) key(KEY_NOT, i);
         key(KEY_AND, 0);
      end
      for (int p = 0; p < 16; p++) apply(4'(p));
      repeat (6) apply(4'($random(seed)));
      $display("test program A done");
      // Program B: one (inverted twice) or not two; then recall A and clear it
      key(KEY_SEL_B, 0);
      key(KEY_INPUT, 0);
      key(KEY_NOT, 0);
      key(KEY_NOT, 0);
      key(KEY_OR, 0);
      key(KEY_INPUT, 1);
      key(KEY_NOT, 1);
      for (int p = 0; p < 16; p++) apply(4'(p));
      key(KEY_SEL_A, 0);
      apply(4'hA);
      apply(4'h1);
      key(KEY_CLEAR, 0);
      apply(4'hA);
      key(KEY_SEL_B, 0);
      apply(4'h2);
      apply(4'h1);
      $display("test recall and clear done");
      // Sync mode gates trigger-out only
      wr(CTRL_OFS, 32'h1 << CTRL_EXT_SYNC);
      xs = 1'b1;
      apply(4'h1);
      wr(CTRL_OFS, 32'h0);
      xs = 1'b0;
      apply(4'h1);
      $display("test sync mode done");
      // Sticky interrupt, masked, then cleared
      apply(4'h2);
      wr(IRQ_STAT_OFS, 32'h3);
      wr(IRQ_MASK_OFS, 32'h0);
      apply(4'h1);
      irqchk(1'b0);
      rchk(IRQ_STAT_OFS, 32'h1);
      wr(IRQ_MASK_OFS, 32'h1);
      irqchk(1'b1);
      wr(IRQ_STAT_OFS, 32'h1);
      irqchk(1'b0);
      $display("test interrupt done");
      // Filter of 8: two 6-cycle spans must not pass
      apply(4'h2);
      wr(FILT_OFS, 32'h8);
      h0 = hi;
      i_probe.set_in(4'h1);
      repeat (5) @(posedge sys_clk);
      i_probe.set_in(4'h2);
      @(posedge sys_clk);
      i_probe.set_in(4'h1);
      repeat (5) @(posedge sys_clk);
      i_probe.set_in(4'h2);
      repeat (10) @(posedge sys_clk);
      chk_word("filtered high cycles", h0, hi);
      i_probe.set_in(4'h1);
      repeat (30) @(posedge sys_clk);
      #1;
      chk_bit("long true span", 1'b1, tb_trig);
      wr(FILT_OFS, 32'h0);
      apply(4'h2);
      $display("test filter done");
      // Qualify on rising, then falling, edges
      wr(CTRL_OFS, 32'h1 << CTRL_QUAL_EN);
      i_probe.set_in(4'h1);
      repeat (8) @(posedge sys_clk);
      #1;
      chk_bit("unqualified", 1'b0, tb_trig);
      h0 = hi;
      i_probe.set_q(1'b1);
      repeat (8) @(posedge sys_clk);
      chk_bit("rising qualified", 1'b1, hi != h0);
      wr(CTRL_OFS, 32'h3);
      i_probe.set_in(4'h2);
      i_probe.set_q(1'b0);
      i_probe.set_in(4'h1);
      repeat (8) @(posedge sys_clk);
      h0 = hi;
      i_probe.set_q(1'b1);
      repeat (8) @(posedge sys_clk);
      chk_word("rising ignored", h0, hi);
      i_probe.set_q(1'b0);
      repeat (8) @(posedge sys_clk);
      chk_bit("falling qualified", 1'b1, hi != h0);
      $display("test qualification done");
      // Raise/lower need channel mode and monitor
      wr(CTRL_OFS, 32'h0);
      wr(THR_SEL_OFS, 32'h2);
      key(KEY_RAISE, 2);
      wr(CTRL_OFS, 32'h1 << CTRL_THR_MON);
      key(KEY_RAISE, 2);
      chk_word("thresholds", {4{THR_TTL_PRESET}}, thr);
      wr(CTRL_OFS, 32'h30);
      key(KEY_RAISE, 2);
      key(KEY_LOWER, 2);
      key(KEY_LOWER, 2);
      rchk(THR0_OFS, {THR_TTL_PRESET, THR_TTL_PRESET - 8'h01, THR_TTL_PRESET, THR_TTL_PRESET});
      wr(CTRL_OFS, 32'h1 << CTRL_ECL);
      rchk(THR0_OFS, {4{THR_ECL_PRESET}});
      wr(CTRL_OFS, 32'h0);
      $display("test thresholds done");
      end_sim();
   end
endmodule
